// *** pssc_pkg.sv ***
// constants and carrier types for the pipelined synchronous memory front end
// assumes every user shares one clock with the memory controller
package pssc_pkg;

   // organisations, named by data-bus width
   localparam int PSSC_ORG_X18   = 18;
   localparam int PSSC_ORG_X32   = 32;
   localparam int PSSC_ORG_X36   = 36;
   localparam int PSSC_LANES_X18 = 2;

   // bus geometry
   localparam int PSSC_ADDR_MAX  = 18;
   localparam int PSSC_ADDR_X18  = 18;
   localparam int PSSC_ADDR_WIDE = 17;
   localparam int PSSC_LANE_MAX  = 4;
   localparam int PSSC_LANE_W    = 9;
   localparam int PSSC_PAR_POS   = 8;
   localparam int PSSC_BURST_W   = 2;

   // burst counter
   localparam logic [1:0] PSSC_BURST_FIRST = 2'h0;
   localparam logic [1:0] PSSC_BURST_STEP  = 2'h1;

   // async pins: {sleep, output enable low, linear select low}
   localparam logic [2:0] PSSC_ASYNC_RST = 3'h3;
   localparam int         PSSC_ASYNC_SLP = 2;
   localparam int         PSSC_ASYNC_OE  = 1;
   localparam int         PSSC_ASYNC_LIN = 0;

   // synchronous command pins, sampled on the rising clock edge
   typedef struct packed {
      logic [PSSC_ADDR_MAX-1:0] sync_address;
      logic                     chip_select_low;
      logic                     chip_select_low_two;
      logic                     chip_select_high;
      logic                     read_not_write;
      logic                     advance_not_load;
      logic                     lane_d_write_enable_low;
      logic                     lane_c_write_enable_low;
      logic                     lane_b_write_enable_low;
      logic                     lane_a_write_enable_low;
   } pssc_cmd_t;

   // one decoded array access
   typedef struct packed {
      logic                     valid;
      logic                     write;
      logic [PSSC_ADDR_MAX-1:0] addr;
      logic [PSSC_LANE_MAX-1:0] lane_we;
   } pssc_op_t;

endpackage : pssc_pkg

// *** pssc_mem.sv ***
// lane-split storage array with one read and one lane-masked write port
// assumes caller gates both ports with its clock enable
`timescale 1ns/1ps
module pssc_mem #(
   parameter int AW = 18,
   parameter int NL = 4,
   parameter int LW = 9
) (
   // clock
   input  wire logic             clk,
   // read port, data registered
   input  wire logic             rd_en,
   input  wire logic [AW-1:0]    rd_addr,
   output logic      [NL*LW-1:0] rd_data,
   // write port
   input  wire logic [NL-1:0]    wr_lane,
   input  wire logic [AW-1:0]    wr_addr,
   input  wire logic [NL*LW-1:0] wr_data
);

   genvar i;
   generate
      for (i = 0; i < NL; i++) begin : g_lane
         logic [LW-1:0] store [2**AW];
         logic [LW-1:0] rd_q;
         logic [LW-1:0] rd_d;

         always_comb begin
            rd_d = rd_en ? store[rd_addr] : rd_q;
         end

         always_ff @(posedge clk) begin
            rd_q <= rd_d;
            if (wr_lane[i]) begin
               store[wr_addr] <= wr_data[i*LW +: LW];
            end
         end

         assign rd_data[i*LW +: LW] = rd_q;
      end
   endgenerate

endmodule : pssc_mem

// *** pssc_sram.sv ***
// pipelined no-turnaround synchronous memory: command capture, burst, array
// assumes controller is clocked by CORE_CLK; sleep, output enable and
// burst-order pins are asynchronous
//
// How it works
// - address, low two bits included, captured in registers at rising edge
// - address, data, selects, lane enables, burst control sampled only at edge
// - x18: lane a enable gates data a and parity a, b likewise
// - x32/x36: enables a to d each gate own lane and parity bit
// - parity stored only in x18 and x36; x32 parity positions unused
// - first low chip select sampled only on load cycles
// - all three chip selects must be active on load for an access
// - clock enable high freezes command, burst, array and data-out state, extending previous cycle
// - asynchronous sleep enters standby, array contents kept
// - while asleep every other input but RESET is ignored; the clock still runs the pin sync flops
// - read/write select decides type only on load cycles
// - burst keeps its type; only a new load changes it
// - write cycle updates only lanes whose enable is low
// - all lane enables low writes full bus width
// - asynchronous low output enable turns data drivers on
// - advance high steps burst counter; low loads a new address
// - burst order: low linear, high interleaved, held static in use
`timescale 1ns/1ps
module pssc_sram
   import pssc_pkg::*;
#(
   parameter int ORG    = pssc_pkg::PSSC_ORG_X36,
   parameter int ADDR_W = (ORG == pssc_pkg::PSSC_ORG_X18) ?
                          pssc_pkg::PSSC_ADDR_X18 : pssc_pkg::PSSC_ADDR_WIDE,
   parameter int NLANE  = (ORG == pssc_pkg::PSSC_ORG_X18) ?
                          pssc_pkg::PSSC_LANES_X18 : pssc_pkg::PSSC_LANE_MAX,
   parameter int DW     = NLANE * pssc_pkg::PSSC_LANE_W
) (
   // clock and reset
   input  wire logic                CORE_CLK,
   input  wire logic                RESET,
   // synchronous command pins
   input  wire pssc_pkg::pssc_cmd_t CMD,
   input  wire logic                CLOCK_ENABLE_LOW,
   // asynchronous pins
   input  wire logic                SLEEP_REQUEST,
   input  wire logic                OUTPUT_ENABLE_LOW,
   input  wire logic                LINEAR_BURST_SELECT_LOW,
   // data bus, split into in, out, enable
   input  wire logic [DW-1:0]       DQ_IN,
   output logic      [DW-1:0]       DQ_OUT,
   output logic                     DQ_OE,
   // status
   output logic                     SLEEP_ACTIVE
);

   import pssc_pkg::*;

   localparam bit HAS_PAR = (ORG != PSSC_ORG_X32);
   localparam logic [PSSC_LANE_MAX-1:0] LANE_MASK =
      PSSC_LANE_MAX'((1 << NLANE) - 1);

   // asynchronous pins, two flops each
   logic [2:0] async_in;
   logic [2:0] meta_q, meta_d, stab_q, stab_d;
   logic       sleep, oe_on, linear, run;

   assign async_in = {SLEEP_REQUEST, OUTPUT_ENABLE_LOW,
                      LINEAR_BURST_SELECT_LOW};

   always_comb begin
      meta_d = async_in;
      stab_d = meta_q;
   end

   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         meta_q <= PSSC_ASYNC_RST;
         stab_q <= PSSC_ASYNC_RST;
      end else begin
         meta_q <= meta_d;
         stab_q <= stab_d;
      end
   end

   assign sleep  = stab_q[PSSC_ASYNC_SLP];
   assign oe_on  = !stab_q[PSSC_ASYNC_OE];
   assign linear = !stab_q[PSSC_ASYNC_LIN];
   assign run    = !CLOCK_ENABLE_LOW && !sleep;

   // command capture
   pssc_cmd_t cmd_q, cmd_d;

   always_comb begin
      cmd_d = run ? CMD : cmd_q;
   end

   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         cmd_q <= '0;
      end else begin
         cmd_q <= cmd_d;
      end
   end

   // burst tracking and access decode
   logic                     burst_act_q, burst_act_d;
   logic                     burst_wr_q, burst_wr_d;
   logic [ADDR_W-1:0]        base_q, base_d;
   logic [PSSC_BURST_W-1:0]  cnt_q, cnt_d;
   pssc_op_t                 op_q, op_d;
   logic                     selected;
   logic [PSSC_BURST_W-1:0]  seq;
   logic [PSSC_LANE_MAX-1:0] bw_low;

   assign bw_low = {cmd_q.lane_d_write_enable_low,
                    cmd_q.lane_c_write_enable_low,
                    cmd_q.lane_b_write_enable_low,
                    cmd_q.lane_a_write_enable_low};
   assign selected = !cmd_q.chip_select_low &&
                     !cmd_q.chip_select_low_two &&
                     cmd_q.chip_select_high;

   always_comb begin
      burst_act_d = burst_act_q;
      burst_wr_d  = burst_wr_q;
      base_d      = base_q;
      cnt_d       = cnt_q;
      op_d        = op_q;
      seq         = '0;
      if (run) begin
         op_d = '0;
         if (!cmd_q.advance_not_load) begin
            burst_act_d = selected;
            burst_wr_d  = !cmd_q.read_not_write;
            base_d      = cmd_q.sync_address[ADDR_W-1:0];
            cnt_d       = PSSC_BURST_FIRST;
         end else if (burst_act_q) begin
            cnt_d = cnt_q + PSSC_BURST_STEP;
         end
         if (linear) begin
            seq = base_d[PSSC_BURST_W-1:0] + cnt_d;
         end else begin
            seq = base_d[PSSC_BURST_W-1:0] ^ cnt_d;
         end
         if (burst_act_d) begin
            op_d.valid = 1'b1;
            op_d.write = burst_wr_d;
            op_d.addr  = PSSC_ADDR_MAX'({base_d[ADDR_W-1:PSSC_BURST_W],
                                         seq});
            op_d.lane_we = burst_wr_d ? (~bw_low & LANE_MASK)
                                      : '0;
         end
      end
   end

   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         burst_act_q <= 1'b0;
         burst_wr_q  <= 1'b0;
         base_q      <= '0;
         cnt_q       <= PSSC_BURST_FIRST;
         op_q        <= '0;
      end else begin
         burst_act_q <= burst_act_d;
         burst_wr_q  <= burst_wr_d;
         base_q      <= base_d;
         cnt_q       <= cnt_d;
         op_q        <= op_d;
      end
   end

   // array ports: read one edge after decode, write data one edge later
   logic             rd_en;
   logic [NLANE-1:0] wr_lane;
   logic [DW-1:0]    wr_data, rd_data;
   logic             addr_hit;

   assign rd_en   = run && op_d.valid && !op_d.write;
   assign wr_lane = (run && op_q.valid && op_q.write) ?
                    op_q.lane_we[NLANE-1:0] : '0;
   assign addr_hit = (op_d.addr == op_q.addr);

   genvar i;
   generate
      for (i = 0; i < NLANE; i++) begin : g_wlane
         // lane enable covers its data bits and parity bit
         assign wr_data[i*PSSC_LANE_W +: PSSC_PAR_POS] =
            DQ_IN[i*PSSC_LANE_W +: PSSC_PAR_POS];
         assign wr_data[i*PSSC_LANE_W + PSSC_PAR_POS] =
            HAS_PAR && DQ_IN[i*PSSC_LANE_W + PSSC_PAR_POS];
      end
   endgenerate

   pssc_mem #(
      .AW (ADDR_W),
      .NL (NLANE),
      .LW (PSSC_LANE_W)
   ) u_mem (
      .clk     (CORE_CLK),
      .rd_en   (rd_en),
      .rd_addr (op_d.addr[ADDR_W-1:0]),
      .rd_data (rd_data),
      .wr_lane (wr_lane),
      .wr_addr (op_q.addr[ADDR_W-1:0]),
      .wr_data (wr_data)
   );

   // output stage with write-to-read forwarding
   logic [NLANE-1:0] byp_q, byp_d;
   logic [DW-1:0]    bdat_q, bdat_d, out_q, out_d;
   logic             rdp_q, rdp_d, rdo_q, rdo_d, oe_q, oe_d, slp_q, slp_d;

   always_comb begin
      byp_d  = byp_q;
      bdat_d = bdat_q;
      rdp_d  = rdp_q;
      rdo_d  = rdo_q;
      out_d  = out_q;
      if (run) begin
         byp_d  = rd_en && addr_hit ? wr_lane : '0;
         bdat_d = wr_data;
         rdp_d  = rd_en;
         rdo_d  = rdp_q;
         for (int l = 0; l < NLANE; l++) begin
            out_d[l*PSSC_LANE_W +: PSSC_LANE_W] = byp_q[l] ?
               bdat_q[l*PSSC_LANE_W +: PSSC_LANE_W] :
               rd_data[l*PSSC_LANE_W +: PSSC_LANE_W];
         end
      end
      oe_d  = oe_on && rdo_q && !sleep;
      slp_d = sleep;
   end

   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         byp_q  <= '0;
         bdat_q <= '0;
         rdp_q  <= 1'b0;
         rdo_q  <= 1'b0;
         out_q  <= '0;
         oe_q   <= 1'b0;
         slp_q  <= 1'b0;
      end else begin
         byp_q  <= byp_d;
         bdat_q <= bdat_d;
         rdp_q  <= rdp_d;
         rdo_q  <= rdo_d;
         out_q  <= out_d;
         oe_q   <= oe_d;
         slp_q  <= slp_d;
      end
   end

   assign DQ_OUT       = out_q;
   assign DQ_OE        = oe_q;
   assign SLEEP_ACTIVE = slp_q;

   // checks
   property p_capture;
      @(posedge CORE_CLK) disable iff (RESET)
      run |=> cmd_q == $past(CMD);
   endproperty
   a_capture: assert property (p_capture)
      else $error("command not captured on enabled edge");

   property p_freeze;
      @(posedge CORE_CLK) disable iff (RESET)
      (CLOCK_ENABLE_LOW && !sleep) |=>
         $stable(op_q) && $stable(DQ_OUT) && $stable(cnt_q);
   endproperty
   a_freeze: assert property (p_freeze)
      else $error("state moved while clock disabled");

   property p_asleep;
      @(posedge CORE_CLK) disable iff (RESET)
      sleep ##1 sleep |-> $stable(op_q) && !DQ_OE && wr_lane == '0;
   endproperty
   a_asleep: assert property (p_asleep)
      else $error("activity while asleep");

   property p_deselect;
      @(posedge CORE_CLK) disable iff (RESET)
      (run && !cmd_q.advance_not_load && !selected) |=>
         !op_q.valid && (wr_lane == '0);
   endproperty
   a_deselect: assert property (p_deselect)
      else $error("access issued without all selects");

   property p_keep_type;
      @(posedge CORE_CLK) disable iff (RESET)
      (run && cmd_q.advance_not_load && burst_act_q) |=>
         op_q.valid && op_q.write == $past(burst_wr_q);
   endproperty
   a_keep_type: assert property (p_keep_type)
      else $error("burst changed type without a load");

   property p_lanes;
      @(posedge CORE_CLK) disable iff (RESET)
      (run && $past(run) && op_q.valid && op_q.write) |->
         wr_lane == $past(~bw_low[NLANE-1:0]);
   endproperty
   a_lanes: assert property (p_lanes)
      else $error("written lanes differ from lane enables");

   property p_read_lat;
      @(posedge CORE_CLK) disable iff (RESET)
      (run && op_d.valid && !op_d.write) ##1 run |=> rdo_q;
   endproperty
   a_read_lat: assert property (p_read_lat)
      else $error("read data not presented two edges on");

   property p_linear;
      @(posedge CORE_CLK) disable iff (RESET)
      (run && linear && cmd_q.advance_not_load && burst_act_q) |=>
         op_q.addr[PSSC_BURST_W-1:0] ==
            $past(base_q[PSSC_BURST_W-1:0] + cnt_q + PSSC_BURST_STEP);
   endproperty
   a_linear: assert property (p_linear)
      else $error("linear burst step wrong");

   property p_oe;
      @(posedge CORE_CLK) disable iff (RESET)
      !oe_on |=> !DQ_OE;
   endproperty
   a_oe: assert property (p_oe)
      else $error("drivers on while output enable high");

   property p_parity;
      @(posedge CORE_CLK) disable iff (RESET)
      !HAS_PAR |-> !DQ_OUT[PSSC_PAR_POS];
   endproperty
   a_parity: assert property (p_parity)
      else $error("parity bit seen in x32 organisation");

endmodule : pssc_sram

// *** pssc_ctrl_model.sv ***
// controller-side data bus model: drives write data, else sees the memory
// assumes one clock shared with the memory and no pull on the bus
`timescale 1ns/1ps
module pssc_ctrl_model #(
   parameter int DW = 36
) (
   // clock
   input  wire logic          clk,
   // controller write drive
   input  wire logic          drv,
   input  wire logic [DW-1:0] wd,
   // memory side of the bus
   input  wire logic [DW-1:0] dq_out,
   input  wire logic          dq_oe,
   output logic      [DW-1:0] dq_in
);
   logic [DW-1:0] last_q;

   // released bus shows the inverse of its last level
   always_comb begin
      if (drv) begin
         dq_in = wd;
      end else if (dq_oe) begin
         dq_in = dq_out;
      end else begin
         dq_in = ~last_q;
      end
   end

   always_ff @(posedge clk) begin
      last_q <= dq_in;
   end
endmodule : pssc_ctrl_model

// *** pssc_sram_bench.sv ***
// self-checking bench for the pipelined synchronous memory front end
// assumes the x36 organisation and the two-edge pipeline of the design
`timescale 1ns/1ps
module pssc_sram_bench;
   import pssc_pkg::*;
   localparam int DW = PSSC_LANE_MAX * PSSC_LANE_W;
   logic          clk = 1'b0;
   logic          rst = 1'b1;
   pssc_cmd_t     cmd, idle;
   logic          cke_l, slp, oe_l, lbs, drv;
   logic          ce, sl, oe, lin, dq_oe, slp_act;
   logic [DW-1:0] wd, dq_in, dq_out;
   logic [DW-1:0] m [4];
   int            err_total = 0;
   int            n_checks = 0;
   int            cyc = 0;

   pssc_sram dut (.CORE_CLK(clk), .RESET(rst), .CMD(cmd),
      .CLOCK_ENABLE_LOW(cke_l), .SLEEP_REQUEST(slp),
      .OUTPUT_ENABLE_LOW(oe_l), .LINEAR_BURST_SELECT_LOW(lbs),
      .DQ_IN(dq_in), .DQ_OUT(dq_out), .DQ_OE(dq_oe),
      .SLEEP_ACTIVE(slp_act));
   pssc_ctrl_model #(.DW(DW)) ctrl (.clk(clk), .drv(drv), .wd(wd),
      .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in));

   always #2.5 clk = ~clk;

   function automatic pssc_cmd_t mk(logic [17:0] a, logic rnw, logic adv,
                                    logic [3:0] ln, logic [2:0] sel);
      mk = {a, sel, rnw, adv, ln};
   endfunction : mk

   function automatic logic [DW-1:0] pat(int i);
      pat = 36'h1_2345_6789 + 36'(i) * 36'h0_1111_1111;
   endfunction : pat

   task automatic chk(string nm, logic [DW-1:0] got, logic [DW-1:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic final_report();
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : final_report

   // one clock step: new pin levels at the edge, settled outputs after
   task automatic st(pssc_cmd_t c, logic [DW-1:0] w, logic d);
      @(posedge clk);
      cmd <= c;
      wd <= w;
      drv <= d;
      cke_l <= ce;
      slp <= sl;
      oe_l <= oe;
      lbs <= lin;
      #1;
   endtask : st

   // single load access; read data stands on return
   task automatic acc(logic [17:0] a, logic rnw, logic [3:0] ln,
                      logic [2:0] sel, logic [DW-1:0] w);
      st(mk(a, rnw, 1'b0, ln, sel), '0, 1'b0);
      st(idle, '0, 1'b0);
      st(idle, w, !rnw);
      st(idle, '0, 1'b0);
   endtask : acc

   task automatic t_stream();
      for (int i = 0; i < 8; i++) begin
         st(i < 4 ? mk(18'h20 + 18'(i), 1'b0, 1'b0, 4'h0, 3'b001) :
            i == 4 ? mk(18'h20, 1'b1, 1'b0, 4'hF, 3'b001) : idle,
            pat(i - 2), i >= 2 && i < 6);
         if (i < 4) m[i] = pat(i);
      end
      chk("read after write", dq_out, m[0]);
   endtask : t_stream

   task automatic t_lanes();
      for (int l = 0; l < 4; l++) begin
         acc(18'h20 + 18'(l), 1'b0, ~(4'h1 << l), 3'b001, ~m[l]);
         m[l] = m[l] ^ (36'h0_0000_01FF << (9 * l));
         acc(18'h20 + 18'(l), 1'b1, 4'hF, 3'b001, '0);
         chk("lane write", dq_out, m[l]);
      end
   endtask : t_lanes

   task automatic t_select();
      for (int s = 0; s < 3; s++) begin
         acc(18'h22, 1'b0, 4'h0, 3'b001 ^ (3'b001 << s), ~m[2]);
         acc(18'h22, 1'b1, 4'hF, 3'b001, '0);
         chk("deselected write", dq_out, m[2]);
      end
   endtask : t_select

   // advance beats carry a write request that must not turn the burst
   task automatic t_burst(logic mode);
      lin = mode;
      repeat (3) st(idle, '0, 1'b0);
      for (int i = 0; i < 7; i++) begin
         st(i == 0 ? mk(18'h21, 1'b1, 1'b0, 4'hF, 3'b001) :
            i < 4 ? mk(18'h0, 1'b0, 1'b1, 4'hF, 3'b001) : idle,
            '0, 1'b0);
         if (i >= 3) chk("burst data", dq_out,
            m[mode ? (1 ^ (i - 3)) : ((i - 2) & 3)]);
         if (i >= 4) chk("burst drive", dq_oe, 1'b1);
      end
   endtask : t_burst

   task automatic t_stall();
      for (int i = 0; i < 8; i++) begin
         ce = (i >= 2 && i <= 4);
         st(i < 2 ? mk(18'h20 + 18'(2 * i), 1'b1, 1'b0, 4'hF, 3'b001) :
            idle, '0, 1'b0);
         if (i >= 6) chk("stalled read", dq_out, m[2 * (i - 6)]);
      end
   endtask : t_stall

   task automatic t_sleep();
      sl = 1'b1;
      repeat (5) st(idle, '0, 1'b0);
      chk("sleep status", slp_act, 1'b1);
      acc(18'h23, 1'b0, 4'h0, 3'b001, ~m[3]);
      chk("drive asleep", dq_oe, 1'b0);
      sl = 1'b0;
      repeat (5) st(idle, '0, 1'b0);
      chk("sleep status", slp_act, 1'b0);
      acc(18'h23, 1'b1, 4'hF, 3'b001, '0);
      chk("kept data", dq_out, m[3]);
   endtask : t_sleep

   task automatic t_oe();
      oe = 1'b1;
      repeat (3) st(idle, '0, 1'b0);
      acc(18'h21, 1'b1, 4'hF, 3'b001, '0);
      st(idle, '0, 1'b0);
      chk("drive off", dq_oe, 1'b0);
      oe = 1'b0;
   endtask : t_oe

   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         err_total++;
         final_report();
      end
   end

   initial begin
      idle = mk('0, 1'b1, 1'b0, 4'hF, 3'b000);
      cmd = idle;
      {ce, sl, oe, lin, drv} = '0;
      {cke_l, slp, oe_l, lbs} = '0;
      wd = '0;
      repeat (5) @(posedge clk);
      #1;
      chk("reset data", dq_out, '0);
      @(posedge clk);
      rst <= 1'b0;
      repeat (3) st(idle, '0, 1'b0);
      chk("reset drive", dq_oe, 1'b0);
      chk("reset sleep", slp_act, 1'b0);
      t_stream();
      t_lanes();
      t_select();
      t_burst(1'b0);
      t_burst(1'b1);
      t_stall();
      t_sleep();
      t_oe();
      final_report();
   end
endmodule : pssc_sram_bench
